// File: logic/sifm_top.v
/*
 * Servo I/O function map: output terminal function selection, input
 * terminal assignment with force masks, preset completion delay, and a
 * small register port.
 * Assumes drive status inputs are on CLK_I already; terminal pins are
 * asynchronous and are synchronised here.
 */
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sifm_map.vh"

module sifm_top
#(
    parameter NUM_DI        = 4,
    parameter NUM_DO        = 4,
    parameter DW            = 16,
    parameter CYCLES_PER_MS = `SIFM_MS_IN_NS / `SIFM_CLK_PERIOD_NS
)
(
    input  wire              CLK_I,
    input  wire              RST_N_I,
    // Register port
    input  wire [5:0]        ADDR_I,
    input  wire [DW-1:0]     WDATA_I,
    input  wire              WR_I,
    input  wire              RD_I,
    output reg  [DW-1:0]     RDATA_O,
    // Drive status
    input  wire              MAIN_POWER_OK_I,
    input  wire              FAULT_I,
    input  wire [1:0]        CTRL_MODE_I,
    input  wire [DW-1:0]     MOTOR_SPEED_I,
    input  wire [DW-1:0]     SPEED_CMD_I,
    input  wire [DW-1:0]     MOTOR_TORQUE_I,
    input  wire [DW-1:0]     POS_DEVIATION_I,
    input  wire              BRAKE_RELEASE_I,
    input  wire              MOTOR_EXCITED_I,
    input  wire              TORQUE_LIMIT_HIT_I,
    input  wire              SPEED_LIMIT_HIT_I,
    input  wire              ORIGIN_DONE_I,
    input  wire              PRESET_FINISHED_I,
    input  wire              INDEX_VALID_I,
    // Terminals
    input  wire [NUM_DI-1:0] DI_PIN_I,
    output reg  [NUM_DO-1:0] DO_PIN_O,
    output reg  [39:0]       IN_FUNC_O
);

    // =================================================================
    // Helpers
    // Magnitude of a two's complement value
    function [DW-1:0] sifm_abs;
        input [DW-1:0] v;
        begin
            sifm_abs = v[DW-1] ? (~v + {{(DW-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    // Register index match inside a block of consecutive offsets
    function sifm_hit;
        input [5:0] addr;
        input [5:0] base;
        input [5:0] idx;
        begin
            sifm_hit = (addr == (base + idx));
        end
    endfunction

    // Arrival compare with optional inversion; equal counts as not arrived unless inverted
    function sifm_arrive;
        input [DW-1:0] mag;
        input [DW-1:0] thr;
        input          inv;
        begin
            sifm_arrive = (mag > thr) ^ inv;
        end
    endfunction

    // Control mode decode shared by the mode-gated output codes
    function sifm_mode_is;
        input [1:0] mode;
        input [1:0] want;
        begin
            sifm_mode_is = (mode == want);
        end
    endfunction

    // =================================================================
    // Register map, one word per index; narrow registers use the low bits
    //   0x00-0x04  force masks A to E, stored whole
    //   0x08+i     input terminal i assignment: 0 none, n is function n-1
    //   0x10+i     output terminal i function code
    //   0x18-0x1B  speed arrival, torque arrival, near position, speed match
    //   0x1C       completion delay in ms; larger writes clamp to 200
    //   0x1D       polarity: bit 0 speed arrival, bit 1 torque arrival
    //   0x20-0x21  read only: output pins, synchronised input pins
    //   0x22-0x26  read only: input function bytes A to E
    // Unmapped reads give zero and unmapped writes are dropped

    // =================================================================
    // Registers
    reg  [7:0]    mask_r [0:4];
    reg  [5:0]    assign_r [0:NUM_DI-1];
    reg  [4:0]    select_r [0:NUM_DO-1];
    reg  [DW-1:0] spd_arr_r;
    reg  [DW-1:0] trq_arr_r;
    reg  [DW-1:0] near_pos_r;
    reg  [DW-1:0] spd_match_r;
    reg  [7:0]    delay_ms_r;
    reg  [1:0]    polarity_r;
    reg  [NUM_DI-1:0] di_meta_r;
    reg  [NUM_DI-1:0] di_sync_r;
    reg  [31:0]   prescale_r;
    reg  [7:0]    ms_count_r;
    reg           preset_done_r;
    reg  [DW-1:0] rdata_nxt;
    integer       k;
    integer       j;

    wire [39:0]   force_vec;
    wire [39:0]   used_vec;
    wire [39:0]   func_nxt;
    wire [31:0]   cond;
    wire [DW-1:0] speed_mag;
    wire [DW-1:0] torque_mag;
    wire [DW-1:0] dev_mag;
    wire [DW:0]   speed_err;
    wire [DW:0]   speed_err_mag;
    wire          speed_mode;

    // =================================================================
    // Register writes; clamp the delay so it never exceeds its range
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            for (k = 0; k < 5; k = k + 1)
                mask_r[k] <= `SIFM_RST_MASK;
            for (k = 0; k < NUM_DI; k = k + 1)
                assign_r[k] <= `SIFM_RST_ASSIGN;
            for (k = 0; k < NUM_DO; k = k + 1)
                select_r[k] <= `SIFM_RST_SELECT;
            spd_arr_r   <= `SIFM_RST_THRESH;
            trq_arr_r   <= `SIFM_RST_THRESH;
            near_pos_r  <= `SIFM_RST_THRESH;
            spd_match_r <= `SIFM_RST_THRESH;
            delay_ms_r  <= `SIFM_RST_DELAY;
            polarity_r  <= 2'h0;
        end
        else if (WR_I)
        begin
            for (k = 0; k < 5; k = k + 1)
                if (sifm_hit(ADDR_I, `SIFM_OFS_MASK_A, k[5:0]))
                    mask_r[k] <= WDATA_I[7:0];
            for (k = 0; k < NUM_DI; k = k + 1)
                if (sifm_hit(ADDR_I, `SIFM_OFS_DI_ASSIGN, k[5:0]))
                    assign_r[k] <= WDATA_I[5:0];
            for (k = 0; k < NUM_DO; k = k + 1)
                if (sifm_hit(ADDR_I, `SIFM_OFS_DO_SELECT, k[5:0]))
                    select_r[k] <= WDATA_I[4:0];
            case (ADDR_I)
                `SIFM_OFS_SPD_ARR:   spd_arr_r   <= WDATA_I;
                `SIFM_OFS_TRQ_ARR:   trq_arr_r   <= WDATA_I;
                `SIFM_OFS_NEAR_POS:  near_pos_r  <= WDATA_I;
                `SIFM_OFS_SPD_MATCH: spd_match_r <= WDATA_I;
                `SIFM_OFS_DONE_DELAY:
                    // Compare the whole word so 0x0100 and up clamp too
                    delay_ms_r <= (WDATA_I > `SIFM_MAX_DELAY_MS) ?
                                  `SIFM_MAX_DELAY_MS : WDATA_I[7:0];
                `SIFM_OFS_POLARITY:  polarity_r  <= WDATA_I[1:0];
                default:             polarity_r  <= polarity_r;
            endcase
        end
    end

    // =================================================================
    // Read mux; data appear the cycle after the strobe, zero elsewhere
    always @*
    begin
        rdata_nxt = {DW{1'b0}};
        for (j = 0; j < 5; j = j + 1)
            if (sifm_hit(ADDR_I, `SIFM_OFS_MASK_A, j[5:0]))
                rdata_nxt[7:0] = mask_r[j];
        for (j = 0; j < NUM_DI; j = j + 1)
            if (sifm_hit(ADDR_I, `SIFM_OFS_DI_ASSIGN, j[5:0]))
                rdata_nxt[5:0] = assign_r[j];
        for (j = 0; j < NUM_DO; j = j + 1)
            if (sifm_hit(ADDR_I, `SIFM_OFS_DO_SELECT, j[5:0]))
                rdata_nxt[4:0] = select_r[j];
        for (j = 0; j < 5; j = j + 1)
            if (sifm_hit(ADDR_I, `SIFM_OFS_FUNC_STATE, j[5:0]))
                rdata_nxt[7:0] = IN_FUNC_O[j*8 +: 8];
        case (ADDR_I)
            `SIFM_OFS_SPD_ARR:    rdata_nxt = spd_arr_r;
            `SIFM_OFS_TRQ_ARR:    rdata_nxt = trq_arr_r;
            `SIFM_OFS_NEAR_POS:   rdata_nxt = near_pos_r;
            `SIFM_OFS_SPD_MATCH:  rdata_nxt = spd_match_r;
            `SIFM_OFS_DONE_DELAY: rdata_nxt[7:0] = delay_ms_r;
            `SIFM_OFS_POLARITY:   rdata_nxt[1:0] = polarity_r;
            `SIFM_OFS_DO_STATE:   rdata_nxt[NUM_DO-1:0] = DO_PIN_O;
            `SIFM_OFS_DI_STATE:   rdata_nxt[NUM_DI-1:0] = di_sync_r;
            default:              rdata_nxt = rdata_nxt;
        endcase
    end

    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
            RDATA_O <= {DW{1'b0}};
        else if (RD_I)
            RDATA_O <= rdata_nxt;
        else
            RDATA_O <= {DW{1'b0}};
    end

    // =================================================================
    // Terminal pins are asynchronous: two flops before any use
    // Both stages clear in reset so no stale contact shows as a function
    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
        begin
            di_meta_r <= {NUM_DI{1'b0}};
            di_sync_r <= {NUM_DI{1'b0}};
        end
        else
        begin
            di_meta_r <= DI_PIN_I;
            di_sync_r <= di_meta_r;
        end
    end

    // =================================================================
    // Input functions: force, else assigned terminal, else off
    assign force_vec = {mask_r[4], mask_r[3], mask_r[2], mask_r[1], mask_r[0]};
    // Unused mask positions never raise a function
    assign used_vec  = {`SIFM_USED_E, `SIFM_USED_D, `SIFM_USED_C,
                        `SIFM_USED_B, `SIFM_USED_A};

    genvar f;
    generate
        for (f = 0; f < 40; f = f + 1)
        begin : g_func
            reg term_val;
            integer t;
            // Assign value is function index plus one; zero means none
            always @*
            begin
                term_val = 1'b0;
                for (t = 0; t < NUM_DI; t = t + 1)
                    if (assign_r[t] == f + 1)
                        term_val = term_val | di_sync_r[t];
            end
            assign func_nxt[f] = used_vec[f] & (force_vec[f] | term_val);
        end
    endgenerate

    always @(posedge CLK_I)
    begin
        if (!RST_N_I)
            IN_FUNC_O <= 40'h0;
        else
            IN_FUNC_O <= func_nxt;
    end

    // =================================================================
    // Preset completion delay: ms prescaler plus ms counter, restarted
    // whenever the preset move is not finished
    always @(posedge CLK_I)
    begin
        if (!RST_N_I || !PRESET_FINISHED_I)
        begin
            prescale_r    <= 32'h0;
            ms_count_r    <= 8'h00;
            preset_done_r <= 1'b0;
        end
        // At or past the target: a delay lowered mid-count must not wrap
        else if (ms_count_r >= delay_ms_r)
            preset_done_r <= 1'b1;
        else if (prescale_r == CYCLES_PER_MS - 1)
        begin
            prescale_r <= 32'h0;
            ms_count_r <= ms_count_r + 8'h01;
        end
        else
            prescale_r <= prescale_r + 32'h1;
    end

    // =================================================================
    // Condition vector indexed by output function code
    assign speed_mag     = sifm_abs(MOTOR_SPEED_I);
    assign torque_mag    = sifm_abs(MOTOR_TORQUE_I);
    assign dev_mag       = sifm_abs(POS_DEVIATION_I);
    assign speed_err     = {MOTOR_SPEED_I[DW-1], MOTOR_SPEED_I} -
                           {SPEED_CMD_I[DW-1], SPEED_CMD_I};
    assign speed_err_mag = speed_err[DW] ? (~speed_err + {{DW{1'b0}}, 1'b1})
                                         : speed_err;
    assign speed_mode    = sifm_mode_is(CTRL_MODE_I, `SIFM_MODE_SPEED) ||
                           sifm_mode_is(CTRL_MODE_I, `SIFM_MODE_TORQUE);

    // Codes not listed here stay zero, so the terminal stays off
    assign cond[0]                    = 1'b0;
    assign cond[`SIFM_FC_ALWAYS]      = 1'b1;
    assign cond[`SIFM_FC_READY]       = MAIN_POWER_OK_I & ~FAULT_I;
    assign cond[`SIFM_FC_NO_FAULT]    = ~FAULT_I;
    assign cond[5:4]                  = 2'b00;
    assign cond[`SIFM_FC_SPD_ARR]     = speed_mode &
        sifm_arrive(speed_mag, spd_arr_r, polarity_r[`SIFM_POL_SPEED_BIT]);
    assign cond[`SIFM_FC_TRQ_ARR]     =
        sifm_arrive(torque_mag, trq_arr_r, polarity_r[`SIFM_POL_TORQUE_BIT]);
    assign cond[`SIFM_FC_BRAKE]       = BRAKE_RELEASE_I;
    assign cond[`SIFM_FC_RUN]         = MOTOR_EXCITED_I;
    assign cond[`SIFM_FC_NEAR]        = sifm_mode_is(CTRL_MODE_I, `SIFM_MODE_POS) &
                                        (dev_mag < near_pos_r);
    assign cond[`SIFM_FC_TRQ_LIM]     = TORQUE_LIMIT_HIT_I;
    assign cond[`SIFM_FC_SPD_LIM]     = sifm_mode_is(CTRL_MODE_I, `SIFM_MODE_TORQUE) &
                                        SPEED_LIMIT_HIT_I;
    assign cond[`SIFM_FC_SPD_MATCH]   = speed_err_mag < {1'b0, spd_match_r};
    assign cond[14]                   = 1'b0;
    assign cond[`SIFM_FC_HOME]        = ORIGIN_DONE_I;
    assign cond[`SIFM_FC_PRESET]      = preset_done_r;
    assign cond[17]                   = 1'b0;
    assign cond[`SIFM_FC_INDEX]       = INDEX_VALID_I;
    assign cond[31:19]                = 13'h0000;

    // =================================================================
    // Output terminals, each steered by its own function select
    // Registered so status glitches never reach a terminal pin
    genvar d;
    generate
        for (d = 0; d < NUM_DO; d = d + 1)
        begin : g_do
            always @(posedge CLK_I)
            begin
                if (!RST_N_I)
                    DO_PIN_O[d] <= 1'b0;
                else
                    DO_PIN_O[d] <= cond[select_r[d]];
            end
        end
    endgenerate

endmodule
`default_nettype wire

// File: pkg/sifm_map.vh
/*
 * Constants of the servo I/O function map: register offsets, field
 * positions, reset values, function codes and timing figures.
 * Assumes it is included by bare name from the design file.
 */
// =====================================================================
// =====================================================================
`ifndef SIFM_MAP_VH
`define SIFM_MAP_VH

// =====================================================================
// Register offsets
`define SIFM_OFS_MASK_A      6'h00
`define SIFM_OFS_MASK_B      6'h01
`define SIFM_OFS_MASK_C      6'h02
`define SIFM_OFS_MASK_D      6'h03
`define SIFM_OFS_MASK_E      6'h04
`define SIFM_OFS_DI_ASSIGN   6'h08
`define SIFM_OFS_DO_SELECT   6'h10
`define SIFM_OFS_SPD_ARR     6'h18
`define SIFM_OFS_TRQ_ARR     6'h19
`define SIFM_OFS_NEAR_POS    6'h1A
`define SIFM_OFS_SPD_MATCH   6'h1B
`define SIFM_OFS_DONE_DELAY  6'h1C
`define SIFM_OFS_POLARITY    6'h1D
`define SIFM_OFS_DO_STATE    6'h20
`define SIFM_OFS_DI_STATE    6'h21
`define SIFM_OFS_FUNC_STATE  6'h22

// =====================================================================
// Field positions and reset values
`define SIFM_POL_SPEED_BIT   0
`define SIFM_POL_TORQUE_BIT  1
`define SIFM_RST_MASK        8'h00
`define SIFM_RST_ASSIGN      6'h00
`define SIFM_RST_SELECT      5'h00
`define SIFM_RST_THRESH      16'h0000
`define SIFM_RST_DELAY       8'h00
`define SIFM_MAX_DELAY_MS    8'hC8
// Force mask bits that carry a function
`define SIFM_USED_A          8'hFF
`define SIFM_USED_B          8'hB7
`define SIFM_USED_C          8'h7E
`define SIFM_USED_D          8'h7C
`define SIFM_USED_E          8'h03

// =====================================================================
// Control modes
`define SIFM_MODE_POS        2'h0
`define SIFM_MODE_SPEED      2'h1
`define SIFM_MODE_TORQUE     2'h2

// =====================================================================
// Output function codes
`define SIFM_FC_ALWAYS       1
`define SIFM_FC_READY        2
`define SIFM_FC_NO_FAULT     3
`define SIFM_FC_SPD_ARR      6
`define SIFM_FC_TRQ_ARR      7
`define SIFM_FC_BRAKE        8
`define SIFM_FC_RUN          9
`define SIFM_FC_NEAR         10
`define SIFM_FC_TRQ_LIM      11
`define SIFM_FC_SPD_LIM      12
`define SIFM_FC_SPD_MATCH    13
`define SIFM_FC_HOME         15
`define SIFM_FC_PRESET       16
`define SIFM_FC_INDEX        18

// =====================================================================
// Timing
`define SIFM_CLK_PERIOD_NS   5
`define SIFM_MS_IN_NS        1000000

`endif

// File: testbench/sifm_top_sva.sv
/* Checker for the servo I/O function map top ports.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sifm_top_sva (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic [5:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    input  wire logic [15:0] RDATA_O,
    input  wire logic        MAIN_POWER_OK_I,
    input  wire logic        FAULT_I,
    input  wire logic [1:0]  CTRL_MODE_I,
    input  wire logic        SPEED_LIMIT_HIT_I,
    input  wire logic        INDEX_VALID_I,
    input  wire logic [3:0]  DO_PIN_O,
    input  wire logic [39:0] IN_FUNC_O
);
    logic [4:0] sel0_r;
    // =====================================================================
    // Shadow of output 0 select, rebuilt from bus traffic
    always_ff @(posedge CLK_I)
    begin
        if (!RST_N_I)
            sel0_r <= 5'h00;
        else if (WR_I && ADDR_I == 6'h10)
            sel0_r <= WDATA_I[4:0];
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // =====================================================================
    // Register port
    chk_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
        else $error("read data not zero outside read cycle");
    chk_mask_upper: assert property (RD_I && ADDR_I < 6'h05 |=> RDATA_O[15:8] == 8'h00)
        else $error("mask read upper byte not zero");
    // Read back after a write and one idle cycle
    chk_mask_back: assert property (WR_I && ADDR_I < 6'h05
        ##1 !WR_I ##1 RD_I && ADDR_I == $past(ADDR_I, 2)
        |=> RDATA_O[7:0] == $past(WDATA_I[7:0], 3))
        else $error("mask read back differs");
    chk_delay_clamp: assert property (WR_I && ADDR_I == 6'h1C && WDATA_I > 16'h00C8
        ##1 !WR_I ##1 RD_I && ADDR_I == 6'h1C |=> RDATA_O == 16'h00C8)
        else $error("completion delay not clamped");
    // =====================================================================
    // Force masks; the documented unused bits must never show
    chk_force_on: assert property (WR_I && ADDR_I == 6'h00
        ##1 !(WR_I && ADDR_I == 6'h00)
        |=> (IN_FUNC_O[7:0] & $past(WDATA_I[7:0], 2)) == $past(WDATA_I[7:0], 2))
        else $error("forced function not on");
    chk_null_bits: assert property ((IN_FUNC_O & 40'hFC_8381_4800) == 40'h0)
        else $error("unused function bit on");
    // =====================================================================
    // Output 0 function codes, one edge after the status is sampled
    chk_code_ready: assert property (sel0_r == 5'h02
        |=> DO_PIN_O[0] == $past(MAIN_POWER_OK_I && !FAULT_I))
        else $error("ready output wrong");
    chk_code_fault: assert property (sel0_r == 5'h03 |=> DO_PIN_O[0] == !$past(FAULT_I))
        else $error("no-alarm output wrong");
    chk_code_always: assert property (sel0_r == 5'h01 |=> DO_PIN_O[0])
        else $error("always-on output off");
    chk_code_undef: assert property (sel0_r == 5'h0E || sel0_r == 5'h11 |=> !DO_PIN_O[0])
        else $error("undefined code output on");
    chk_code_spdlim: assert property (sel0_r == 5'h0C
        |=> DO_PIN_O[0] == $past(SPEED_LIMIT_HIT_I && CTRL_MODE_I == 2'h2))
        else $error("speed limit output wrong");
    chk_code_index: assert property (sel0_r == 5'h12 |=> DO_PIN_O[0] == $past(INDEX_VALID_I))
        else $error("index output wrong");
    cov_preset_on: cover property (sel0_r == 5'h10 ##1 DO_PIN_O[0]);
    cov_delay_wr: cover property (WR_I && ADDR_I == 6'h1C);
    cov_force_all: cover property (IN_FUNC_O[7:0] == 8'hFF);
endmodule
bind sifm_top sifm_top_sva i_sifm_top_sva (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MAIN_POWER_OK_I(MAIN_POWER_OK_I),
    .FAULT_I(FAULT_I), .CTRL_MODE_I(CTRL_MODE_I), .SPEED_LIMIT_HIT_I(SPEED_LIMIT_HIT_I),
    .INDEX_VALID_I(INDEX_VALID_I), .DO_PIN_O(DO_PIN_O), .IN_FUNC_O(IN_FUNC_O)
);
`default_nettype wire

// File: testbench/sifm_ctrl_model.sv
/* Machine controller closing the input terminal contacts.
   Assumes the bench says which contacts to close. */
`timescale 1ns/1ps
`default_nettype none
module sifm_ctrl_model (
    input  wire logic [3:0] want_i,
    output var  logic [3:0] pins_o
);
    initial pins_o = 4'h0;
    // =====================================================================
    // Contacts settle off the clock grid, so the synchroniser really works
    always @(want_i)
        pins_o <= #3 want_i;
endmodule
`default_nettype wire

// File: testbench/servo_io_function_map_tb.sv
/* Self-checking bench for the servo I/O function map top.
   Assumes the checker is bound in and the controller model drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module servo_io_function_map_tb;
    localparam int CPMS = 4;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  addr  = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        pwr   = 1'b0;
    logic        flt   = 1'b0;
    logic        fin   = 1'b0;
    logic [1:0]  mode  = 2'h0;
    logic [5:0]  st    = 6'h00; // Brake, excite, torque lim, speed lim, origin, index
    logic [15:0] spd   = 16'h0000;
    logic [15:0] trq   = 16'h0000;
    logic [15:0] cmd   = 16'h0064;
    logic [15:0] dev   = 16'h000A;
    logic [3:0]  want  = 4'h0;
    wire  [3:0]  pins;
    wire  [15:0] rdata;
    wire  [3:0]  dout;
    wire  [39:0] func;
    int          n_fail   = 0;
    int          n_checks = 0;
    always #2.5 clk = ~clk;
    sifm_top #(.CYCLES_PER_MS(CPMS)) i_sifm_top (
        .CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .MAIN_POWER_OK_I(pwr), .FAULT_I(flt), .CTRL_MODE_I(mode),
        .MOTOR_SPEED_I(spd), .SPEED_CMD_I(cmd), .MOTOR_TORQUE_I(trq), .POS_DEVIATION_I(dev),
        .BRAKE_RELEASE_I(st[0]), .MOTOR_EXCITED_I(st[1]), .TORQUE_LIMIT_HIT_I(st[2]),
        .SPEED_LIMIT_HIT_I(st[3]), .ORIGIN_DONE_I(st[4]), .PRESET_FINISHED_I(fin),
        .INDEX_VALID_I(st[5]), .DI_PIN_I(pins), .DO_PIN_O(dout), .IN_FUNC_O(func)
    );
    sifm_ctrl_model i_sifm_ctrl_model (.want_i(want), .pins_o(pins));
    // =====================================================================
    // Bus, compare and settle helpers; all but cmp start right after a rising edge
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Let an edge pass so a following write never re-drives wr in this step
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        cmp(40'(rdata), 40'(e));
        @(posedge clk);
    endtask
    // Four edges covers the two-flop pin synchroniser plus the output register
    task automatic look;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic do_chk(input logic [3:0] e);
        look;
        cmp(40'(dout), 40'(e));
        @(posedge clk);
    endtask
    task automatic fn_chk(input logic [39:0] e);
        look;
        cmp(func, e);
        @(posedge clk);
    endtask
    task automatic set_stat(input logic on);
        pwr  <= on;
        flt  <= !on;
        st   <= {6{on}};
        mode <= on ? 2'h2 : 2'h0;
        spd  <= on ? 16'h0064 : 16'h000A;
        trq  <= on ? 16'h0064 : 16'h000A;
    endtask
    // Output 0 level with thresholds of 50 and the two status patterns
    function automatic logic exp_do(input int c, input logic on);
        case (c)
            1: return 1'b1;
            2, 3, 6, 7, 8, 9, 11, 12, 13, 15, 18: return on;
            10: return !on;
            default: return 1'b0;
        endcase
    endfunction
    // =====================================================================
    // Scenarios
    task automatic t_regs;
        for (int i = 0; i < 5; i++)
            rd_chk(i[5:0], 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(i[5:0], 16'h5AA5 ^ i[15:0]);
            rd_chk(i[5:0], 16'h00A5 ^ i[15:0]);
        end
        rd_chk(6'h05, 16'h0000);
        wr_reg(6'h1C, 16'h01FF);
        rd_chk(6'h1C, 16'h00C8);
        $display("test regs done");
    endtask
    task automatic t_force;
        for (int i = 0; i < 5; i++)
            wr_reg(i[5:0], 16'h00FF);
        fn_chk(40'h03_7C7E_B7FF);
        for (int i = 0; i < 5; i++)
            wr_reg(i[5:0], 16'h0000);
        fn_chk(40'h0);
        $display("test force done");
    endtask
    task automatic t_assign;
        wr_reg(6'h08, 16'h0002);
        want <= 4'b0011;
        fn_chk(40'h2);
        rd_chk(6'h21, 16'h0003);
        rd_chk(6'h22, 16'h0002);
        want <= 4'b0000;
        fn_chk(40'h0);
        wr_reg(6'h00, 16'h0002);
        fn_chk(40'h2);
        wr_reg(6'h00, 16'h0000);
        $display("test assign done");
    endtask
    task automatic t_codes;
        wr_reg(6'h11, 16'h0001);
        wr_reg(6'h12, 16'h0011);
        wr_reg(6'h13, 16'h000E);
        for (int c = 24; c < 28; c++)
            wr_reg(c[5:0], 16'h0032);
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 20; c++)
            begin
                set_stat(p[0]);
                wr_reg(6'h10, c[15:0]);
                do_chk({3'b001, exp_do(c, p[0])});
            end
        wr_reg(6'h1D, 16'h0003);
        for (int c = 6; c < 8; c++)
        begin
            wr_reg(6'h10, c[15:0]);
            do_chk(4'b0010);
        end
        wr_reg(6'h1D, 16'h0000);
        mode <= 2'h1;
        wr_reg(6'h10, 16'h0006);
        do_chk(4'b0011);
        rd_chk(6'h20, 16'h0003);
        wr_reg(6'h10, 16'h000C);
        do_chk(4'b0010);
        mode <= 2'h0;
        dev  <= 16'hFF9C;
        wr_reg(6'h10, 16'h000A);
        do_chk(4'b0010);
        dev  <= 16'hFFF6;
        do_chk(4'b0011);
        $display("test codes done");
    endtask
    task automatic t_preset;
        int n;
        n = 0;
        set_stat(1'b1);
        wr_reg(6'h10, 16'h0010);
        wr_reg(6'h1C, 16'h0002);
        fin <= 1'b1;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (dout[0] !== 1'b1 && n < 40);
        cmp(40'(n), 40'(3 + 2 * CPMS));
        @(posedge clk);
        fin <= 1'b0;
        do_chk(4'b0010);
        $display("test preset done");
    endtask
    // =====================================================================
    // Verdict and run control
    task automatic summarize;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_fail++;
        summarize;
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_force;
        t_assign;
        t_codes;
        t_preset;
        summarize;
    end
endmodule
`default_nettype wire
